// ===== rtl/pwm_defines.svh
// Named levels, ratios and times of the flyback switching controller.
// Assumes 1 mV per code step on the sense and feedback sample buses.
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH

// System clock rate in hertz.
`define SYS_CLK_HZ 20000000
// Soft start length in ms, number of steps, first and final limits in mV.
`define SS_TIME_MS 12
`define SS_STEPS 4
`define SS_START_MV 12'h012C
`define SS_STEP_MV 12'h007D
`define SS_LAST_STEP 2'h3
`define NORMAL_LIMIT_MV 12'h0320
// Peak limit in light-load bursts, burst entry, restart and exit levels in mV.
`define BURST_LIMIT_MV 12'h010E
`define BURST_ENTRY_MV 12'h0406
`define BURST_ON_MV 12'h0640
`define BURST_EXIT_MV 12'h0AAA
// Burst entry blanking time in ms.
`define BURST_BLANK_MS 20
// Frequency reduction starts below this feedback level in mV.
`define FREQ_REDUCE_MV 12'h06A4
// Nominal and floor switching frequency in kHz.
`define FSW_KHZ 65
`define FLOOR_KHZ 20
// Jitter depth in percent and jitter period in ms.
`define JITTER_PCT 4
`define JITTER_MS 4
// Duty ceiling 3/4 and slope compensation start 2/5 of the period.
`define DUTY_NUM 14'h0003
`define DUTY_DEN 14'h0004
`define SLOPE_NUM 14'h0002
`define SLOPE_DEN 14'h0005
// Blanking interval and floor sample delay in ns, sense floor in mV.
`define BLANK_NS 220
`define SAMPLE_NS 1000
`define SENSE_FLOOR_MV 12'h0064
// Pulses with a low sense level before auto restart, minus one.
`define FLOOR_MISS_LAST 2'h2

`endif

// ===== rtl/pwm_pkg.sv
// Types shared by the flyback switching controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package pwm_pkg;

	// Operating phase of the controller.
	typedef enum logic [2:0] {PH_PRE_LOW, PH_PRE_HIGH, PH_SOFT, PH_NORMAL, PH_RESTART} phase_e;

	// Synchronised supply comparator flags.
	typedef struct packed {
		logic aboveOn;
		logic aboveShort;
	} supply_s;

endpackage

// ===== rtl/pin_sync3.sv
// Three-stage synchroniser for asynchronous comparator pins.
// Assumes pins may change at any time relative to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
	parameter int W = 2
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinOut
);
	// All state of the synchroniser.
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_s;

	sync_s r;
	sync_s n;
	logic [W-1:0] qNext; // Agreed value per bit.

	// A bit changes only once the second and third stages agree.
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign qNext[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
	end

	// Next state: shift the pin through the stages.
	always_comb begin
		n = r;
		n.s1 = pinIn;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.q = qNext;
	end

	// State register with synchronous reset.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign pinOut = r.q;
endmodule
`default_nettype wire

// ===== rtl/osc_jitter.sv
// Switching oscillator with frequency reduction and triangular jitter.
// Assumes feedback samples arrive on sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_defines.svh"
module osc_jitter import pwm_pkg::*; #(
	parameter int JITTER_CYC = `JITTER_MS * (`SYS_CLK_HZ / 1000),
	parameter int REDUCE_SHIFT = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [11:0] fbCode,
	input wire logic jitterEn,
	output logic cycleStart,
	output logic [11:0] periodLen
);
	// Nominal and floor periods, jitter depth and jitter step spacing.
	localparam int BASE = `SYS_CLK_HZ / (`FSW_KHZ * 1000);
	localparam int FLOOR = `SYS_CLK_HZ / (`FLOOR_KHZ * 1000);
	localparam int JDEPTH = BASE * `JITTER_PCT / 100;
	localparam int JSTEP = JITTER_CYC / (4 * JDEPTH);

	// All state of the oscillator.
	typedef struct packed {
		logic [11:0] cnt;
		logic signed [7:0] jOff;
		logic jDown;
		logic [15:0] jTick;
		logic start;
		logic [11:0] period;
	} osc_s;

	osc_s r;
	osc_s n;
	logic [12:0] reduced; // Period after frequency reduction.
	logic [12:0] capped; // Period held at the frequency floor.
	logic signed [13:0] target; // Period with jitter added.

	// Period target: longer as feedback falls, held at the floor.
	always_comb begin
		reduced = 13'(BASE);
		if (fbCode < `FREQ_REDUCE_MV) begin
			reduced = 13'(BASE) + 13'((`FREQ_REDUCE_MV - fbCode) >> REDUCE_SHIFT);
		end
		capped = (reduced > 13'(FLOOR)) ? 13'(FLOOR) : reduced;
		target = signed'(14'(capped)) + 14'(r.jOff);
	end

	// Next state: count the period and walk the jitter triangle.
	always_comb begin
		n = r;
		n.start = 1'b0;
		n.cnt = r.cnt + 12'h0001;
		if (r.cnt + 12'h0001 >= 12'(target)) begin
			n.cnt = '0;
			n.start = 1'b1;
			n.period = 12'(target);
		end
		if (!jitterEn) begin
			n.jOff = '0;
			n.jTick = '0;
		end else if (r.jTick >= 16'(JSTEP - 1)) begin
			n.jTick = '0;
			n.jOff = r.jDown ? r.jOff - 8'sd1 : r.jOff + 8'sd1;
			if (!r.jDown && r.jOff >= 8'(JDEPTH - 1)) begin
				n.jDown = 1'b1;
			end else if (r.jDown && r.jOff <= -8'(JDEPTH - 1)) begin
				n.jDown = 1'b0;
			end
		end else begin
			n.jTick = r.jTick + 16'h0001;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= '0;
			r.period <= 12'(BASE);
		end else begin
			r <= n;
		end
	end

	assign cycleStart = r.start;
	assign periodLen = r.period;
endmodule
`default_nettype wire

// ===== rtl/flyback_pwm_startup_control.sv
// Startup sequencing and peak current mode switching of a flyback controller.
// Assumes supply comparator pins are asynchronous and sense and feedback
// samples are 12-bit mV codes delivered by a converter on sys_clk.
//
// How it works
// - precharge small current, then larger current.
// - above turn-on threshold start with soft start.
// - twelve ms four steps raise limit 0.3 to 0.8.
// - feedback loop takes over once output regulates.
// - switch on at each oscillator cycle start.
// - switch off when scaled sense exceeds feedback.
// - blanking interval ignores comparison, sets minimum on-time.
// - force off at three quarters duty.
// - comparison signal is sense times gain plus offset.
// - low sense on three pulses enters auto restart.
// - frequency falls below 1.7 V, held at floor.
// - slope term grows after forty percent on-time.
// - no slope term in light-load burst mode.
// - nominal frequency dithered four percent over 4 ms.
// - jitter only after soft start, kept during reduction.
// - sense above peak limit turns gate off.
// - light load enters burst mode switching.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_defines.svh"
module flyback_pwm_startup_control import pwm_pkg::*; #(
	parameter int SS_STEP_CYC = `SS_TIME_MS * (`SYS_CLK_HZ / 1000) / `SS_STEPS,
	parameter int JITTER_CYC = `JITTER_MS * (`SYS_CLK_HZ / 1000),
	parameter int BURST_BLANK_CYC = `BURST_BLANK_MS * (`SYS_CLK_HZ / 1000),
	parameter logic [15:0] PWM_GAIN = 16'h0003,
	parameter logic [15:0] PWM_OFFSET_MV = 16'h0258,
	parameter logic [15:0] SLOPE_RATE = 16'h0002
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic supplyAboveShortPin,
	input wire logic supplyAboveOnPin,
	input wire logic [11:0] senseCode,
	input wire logic [11:0] fbCode,
	output logic gateOn,
	output logic chargeLowEn,
	output logic chargeHighEn,
	output logic softStartActive,
	output logic burstActive,
	output logic autoRestart
);
	// Blanking and floor sample delays in cycles, rounded up.
	localparam int CLK_PER_US = `SYS_CLK_HZ / 1000000;
	localparam int BLANK_CYC = (`BLANK_NS * CLK_PER_US + 999) / 1000;
	localparam int SAMPLE_CYC = (`SAMPLE_NS * CLK_PER_US + 999) / 1000;

	// All state of the controller.
	typedef struct packed {
		phase_e phase;
		logic [1:0] ssStep;
		logic [16:0] ssCnt;
		logic gate;
		logic [11:0] onCnt;
		logic [1:0] floorMiss;
		logic burst;
		logic burstRun;
		logic [22:0] burstCnt;
		logic chargeLow;
		logic chargeHigh;
		logic jitterEn;
		logic softStart; // Registered copy of the soft start phase for the output pin.
		logic restart; // Registered copy of the auto restart phase for the output pin.
	} ctrl_s;

	ctrl_s r;
	ctrl_s n;
	logic [1:0] supplyRaw; // Synchronised supply comparator pins.
	supply_s supply; // Same flags by name.
	logic cycleStart; // One-cycle pulse at each oscillator period start.
	logic [11:0] periodLen; // Length of the running period in cycles.
	logic [11:0] dutyMax; // On-time ceiling in cycles.
	logic [11:0] slopeStart; // On-time at which slope compensation begins.
	logic [15:0] slopeTerm; // Slope compensation added to the sense level.
	logic [15:0] pwmLevel; // Scaled sense level compared with feedback.
	logic [11:0] ssLimit; // Peak limit of the present soft start step.
	logic [11:0] peakLimit; // Peak limit in force.
	logic switchOk; // Switching is allowed in this period.
	logic blanked; // Comparisons are still masked.
	logic turnOff; // Present pulse ends this cycle.

	// Supply comparator pins come from the analog side.
	pin_sync3 #(.W(2)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pinIn({supplyAboveOnPin, supplyAboveShortPin}),
		.pinOut(supplyRaw)
	);
	assign supply = supply_s'(supplyRaw);

	// Oscillator with frequency reduction and jitter.
	osc_jitter #(.JITTER_CYC(JITTER_CYC)) u_osc (
		.sys_clk(sys_clk),
		.rst(rst),
		.fbCode(fbCode),
		.jitterEn(r.jitterEn),
		.cycleStart(cycleStart),
		.periodLen(periodLen)
	);

	// Derived limits and the comparison level of the current pulse.
	always_comb begin
		dutyMax = 12'((14'(periodLen) * `DUTY_NUM) / `DUTY_DEN);
		slopeStart = 12'((14'(periodLen) * `SLOPE_NUM) / `SLOPE_DEN);
		slopeTerm = '0;
		if (!r.burst && r.onCnt > slopeStart) begin
			slopeTerm = 16'(r.onCnt - slopeStart) * SLOPE_RATE;
		end
		pwmLevel = 16'(senseCode) * PWM_GAIN + PWM_OFFSET_MV + slopeTerm;
		ssLimit = 12'(`SS_START_MV + 12'(r.ssStep) * `SS_STEP_MV);
		if (r.phase == PH_SOFT) begin
			peakLimit = ssLimit;
		end else if (r.burst) begin
			peakLimit = `BURST_LIMIT_MV;
		end else begin
			peakLimit = `NORMAL_LIMIT_MV;
		end
		switchOk = (r.phase == PH_SOFT || r.phase == PH_NORMAL) && (!r.burst || r.burstRun);
		blanked = r.onCnt < 12'(BLANK_CYC);
		// Whichever ends first, feedback or limit, governs the pulse.
		turnOff = (!blanked && pwmLevel > 16'(fbCode))
			|| (!blanked && senseCode > peakLimit)
			|| (r.onCnt + 12'h0001 >= dutyMax);
	end

	// Next state: phase sequencing, gate pulse and burst control.
	always_comb begin
		n = r;
		// Gate pulse: start on the oscillator, end on comparison or ceiling.
		if (r.gate) begin
			n.onCnt = r.onCnt + 12'h0001;
			if (turnOff) begin
				n.gate = 1'b0;
			end
			// Sense floor check a fixed delay into the on-time.
			if (r.onCnt == 12'(SAMPLE_CYC)) begin
				if (senseCode < `SENSE_FLOOR_MV) begin
					n.floorMiss = r.floorMiss + 2'h1;
					if (r.floorMiss == `FLOOR_MISS_LAST) begin
						n.phase = PH_RESTART;
					end
				end else begin
					n.floorMiss = '0;
				end
			end
		end else if (cycleStart && switchOk) begin
			n.gate = 1'b1;
			n.onCnt = '0;
		end
		unique case (r.phase)
			PH_PRE_LOW: begin
				// Small charge current until the short threshold.
				if (supply.aboveShort) begin
					n.phase = PH_PRE_HIGH;
				end
			end
			PH_PRE_HIGH: begin
				// Larger charge current until the turn-on threshold.
				if (supply.aboveOn) begin
					n.phase = PH_SOFT;
					n.ssStep = '0;
					n.ssCnt = '0;
					n.floorMiss = '0;
				end
			end
			PH_SOFT: begin
				// Equal time steps, each raising the peak limit.
				if (r.ssCnt >= 17'(SS_STEP_CYC - 1)) begin
					n.ssCnt = '0;
					if (r.ssStep == `SS_LAST_STEP) begin
						// A floor fault found in this same cycle keeps priority over the handover.
						if (n.phase == PH_SOFT) begin
							n.phase = PH_NORMAL;
						end
					end else begin
						n.ssStep = r.ssStep + 2'h1;
					end
				end else begin
					n.ssCnt = r.ssCnt + 17'h0_0001;
				end
			end
			PH_NORMAL: begin
				if (!r.burst) begin
					// Enter bursts after feedback stays low for the blanking time.
					if (fbCode < `BURST_ENTRY_MV) begin
						n.burstCnt = r.burstCnt + 23'h00_0001;
						if (r.burstCnt >= 23'(BURST_BLANK_CYC - 1)) begin
							n.burst = 1'b1;
							n.burstRun = 1'b0;
						end
					end else begin
						n.burstCnt = '0;
					end
				end else if (fbCode > `BURST_EXIT_MV) begin
					// Load step: back to normal switching at once.
					n.burst = 1'b0;
					n.burstCnt = '0;
				end else if (fbCode > `BURST_ON_MV) begin
					n.burstRun = 1'b1;
				end else if (fbCode < `BURST_ENTRY_MV) begin
					n.burstRun = 1'b0;
				end
			end
			PH_RESTART: begin
				// Wait for the supply to collapse, then precharge again.
				if (!supply.aboveOn) begin
					n.phase = PH_PRE_LOW;
				end
			end
			default: begin
				// Unused phase codes fall back to a fresh precharge.
				n.phase = PH_PRE_LOW;
			end
		endcase
		if (n.phase == PH_RESTART) begin
			n.gate = 1'b0;
			n.burst = 1'b0;
			n.burstRun = 1'b0;
			n.burstCnt = '0;
		end
		n.chargeLow = (n.phase == PH_PRE_LOW);
		n.chargeHigh = (n.phase == PH_PRE_HIGH);
		n.jitterEn = (n.phase == PH_NORMAL);
		n.softStart = (n.phase == PH_SOFT);
		n.restart = (n.phase == PH_RESTART);
	end

	// State register with synchronous reset.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= '0;
			r.phase <= PH_PRE_LOW;
			r.chargeLow <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Outputs come straight from the state register.
	assign gateOn = r.gate;
	assign chargeLowEn = r.chargeLow;
	assign chargeHighEn = r.chargeHigh;
	assign softStartActive = r.softStart;
	assign burstActive = r.burst;
	assign autoRestart = r.restart;

	// Checks on the behaviour above.
	property p_precharge;
		@(posedge sys_clk) disable iff (rst)
		(r.phase == PH_PRE_LOW) && !supply.aboveShort |=> chargeLowEn && !chargeHighEn;
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge current wrong");

	property p_no_early_gate;
		@(posedge sys_clk) disable iff (rst)
		(r.phase == PH_PRE_LOW || r.phase == PH_PRE_HIGH) |-> !gateOn;
	endproperty
	a_no_early_gate: assert property (p_no_early_gate) else $error("gate before turn-on");

	property p_soft_first;
		@(posedge sys_clk) disable iff (rst)
		(r.phase == PH_PRE_HIGH) && supply.aboveOn |=> softStartActive && r.ssStep == 2'h0;
	endproperty
	a_soft_first: assert property (p_soft_first) else $error("no soft start");

	property p_on_sync;
		@(posedge sys_clk) disable iff (rst)
		$rose(gateOn) |-> $past(cycleStart);
	endproperty
	a_on_sync: assert property (p_on_sync) else $error("gate on off-cycle");

	property p_blank;
		@(posedge sys_clk) disable iff (rst)
		$fell(gateOn) && !autoRestart |-> $past(r.onCnt) >= 12'(BLANK_CYC) || $past(r.onCnt) + 12'h0001 >= $past(dutyMax);
	endproperty
	a_blank: assert property (p_blank) else $error("pulse shorter than blanking");

	property p_duty;
		@(posedge sys_clk) disable iff (rst)
		gateOn && !cycleStart |-> r.onCnt < dutyMax;
	endproperty
	a_duty: assert property (p_duty) else $error("duty ceiling exceeded");

	property p_peak;
		@(posedge sys_clk) disable iff (rst)
		gateOn && !blanked && senseCode > peakLimit |=> !gateOn;
	endproperty
	a_peak: assert property (p_peak) else $error("peak limit ignored");

	property p_floor;
		@(posedge sys_clk) disable iff (rst)
		gateOn && r.floorMiss == `FLOOR_MISS_LAST && r.onCnt == 12'(SAMPLE_CYC)
			&& senseCode < `SENSE_FLOOR_MV |=> autoRestart && !gateOn;
	endproperty
	a_floor: assert property (p_floor) else $error("sense floor fault missed");

	property p_slope_burst;
		@(posedge sys_clk) disable iff (rst)
		burstActive |-> pwmLevel == 16'(senseCode) * PWM_GAIN + PWM_OFFSET_MV;
	endproperty
	a_slope_burst: assert property (p_slope_burst) else $error("slope term in burst");

	property p_jitter;
		@(posedge sys_clk) disable iff (rst)
		softStartActive |-> !r.jitterEn;
	endproperty
	a_jitter: assert property (p_jitter) else $error("jitter during soft start");

	property p_restart;
		@(posedge sys_clk) disable iff (rst)
		autoRestart |-> !gateOn ##1 (autoRestart || chargeLowEn);
	endproperty
	a_restart: assert property (p_restart) else $error("switching in auto restart");

	c_normal: cover property (@(posedge sys_clk) disable iff (rst) $rose(r.phase == PH_NORMAL));
	c_burst: cover property (@(posedge sys_clk) disable iff (rst) $rose(burstActive));
	c_restart: cover property (@(posedge sys_clk) disable iff (rst) $rose(autoRestart));
	c_peak_off: cover property (@(posedge sys_clk) disable iff (rst) gateOn && turnOff);
endmodule
`default_nettype wire

// ===== bench/switch_sense_model.sv
// Behavioural power switch with its sense resistor, seen at the sense sample bus.
// Assumes the bench sets the ramp start and slope between pulses at falling edges.
`timescale 1ns/1ns
`default_nettype none
module switch_sense_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic gateOn,
	input wire logic [11:0] senseOffset,
	input wire logic [11:0] senseRamp,
	output logic [11:0] senseCode
);
	// Cycles since the switch closed.
	logic [11:0] onCyc_r;

	// Counts the on-time; an open switch restarts the count.
	always_ff @(posedge sys_clk) begin
		if (rst || !gateOn) begin
			onCyc_r <= 12'h000;
		end else begin
			onCyc_r <= onCyc_r + 12'h001;
		end
	end

	// The primary current ramps while closed; an open switch leaves zero across the resistor.
	assign senseCode = gateOn ? 12'(senseOffset + senseRamp * onCyc_r) : 12'h000;
endmodule
`default_nettype wire

// ===== bench/flyback_pwm_startup_control_tb.sv
// Self-checking bench of the flyback startup sequencer and peak current switching.
// Assumes a 20 MHz clock, inputs driven at falling edges and a shortened soft start.
`timescale 1ns/1ns
`default_nettype none
module flyback_pwm_startup_control_tb;
	// One ordinary switching case: feedback, ramp, lowest peak excluded and expected period after frequency reduction.
	typedef struct packed {
		logic [11:0] fb;
		logic [11:0] ramp;
		logic [11:0] lo;
		logic [11:0] per;
	} row_s;
	logic sys_clk, rst, shortPin, onPin, gateOn, chargeLowEn, chargeHighEn;
	logic softStartActive, burstActive, autoRestart;
	logic [11:0] senseCode, fbCode, senseOffset, senseRamp;
	int mismatches, nTests, cyc, lastRise, ssLen;
	row_s rows [5];

	// Device under test with soft start steps of 700 cycles and a short jitter period.
	flyback_pwm_startup_control #(.SS_STEP_CYC(700), .JITTER_CYC(960), .BURST_BLANK_CYC(50)) dut (
		.sys_clk(sys_clk), .rst(rst), .supplyAboveShortPin(shortPin),
		.supplyAboveOnPin(onPin), .senseCode(senseCode), .fbCode(fbCode), .gateOn(gateOn),
		.chargeLowEn(chargeLowEn), .chargeHighEn(chargeHighEn),
		.softStartActive(softStartActive), .burstActive(burstActive),
		.autoRestart(autoRestart));

	// Switch and sense resistor on the far side of the gate.
	switch_sense_model model (.sys_clk(sys_clk), .rst(rst), .gateOn(gateOn),
		.senseOffset(senseOffset), .senseRamp(senseRamp), .senseCode(senseCode));

	// Clock of 50 ns period.
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Free cycle count and the time spent in soft start.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (softStartActive === 1'b1) begin
			ssLen <= ssLen + 1;
		end
	end

	// Compares a seen value with the expected one and reports a difference.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %0d seen %0d", name, exp, seen);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic complete_run();
		if (mismatches == 0 && nTests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Waits a bounded number of cycles for a signal to take a level.
	task automatic waitBit(ref logic sig, input logic v, input int lim);
		for (int i = 0; i < lim && sig !== v; i++) @(negedge sys_clk);
	endtask

	// Counts cycles with the gate on over a span that should have none.
	task automatic quiet(input int n);
		int highs;
		highs = 0;
		repeat (n) begin
			@(negedge sys_clk);
			highs += (gateOn === 1'b1);
		end
		check("gateQuiet", highs, 0);
	endtask

	// Measures the next pulse: last sense while on, on-time, period and the soft start
	// state at its last on cycle, so a pulse that outlives soft start counts as normal.
	task automatic pulse(output int peak, output int onT, output int per, output logic ss);
		peak = 0;
		onT = 0;
		for (int i = 0; i < 2000 && gateOn !== 1'b1; i++) @(negedge sys_clk);
		per = cyc - lastRise;
		lastRise = cyc;
		ss = softStartActive;
		while (gateOn === 1'b1 && onT < 2000) begin
			peak = senseCode;
			ss = softStartActive;
			onT++;
			@(negedge sys_clk);
		end
	endtask

	// Main sequence: reset, startup, table of cases, then the awkward cases.
	initial begin
		int peak, onT, per, step, lastStep, loP, hiP;
		logic ss, prevSs;
		logic [3:0] seen;
		rows[0] = '{12'h07D0, 12'h00A, 12'h1D2, 12'h133};
		rows[1] = '{12'h05DC, 12'h00A, 12'h12C, 12'h197};
		rows[2] = '{12'h044C, 12'h006, 12'h0A6, 12'h25F};
		rows[3] = '{12'h0DAC, 12'h00A, 12'h320, 12'h133};
		// Long pulse: only the slope term ends it below the peak limit.
		rows[4] = '{12'h0BB8, 12'h006, 12'h316, 12'h133};
		rst = 1'b1;
		shortPin = 1'b0;
		onPin = 1'b0;
		fbCode = 12'h0FA0;
		senseOffset = 12'h000;
		senseRamp = 12'h00A;
		mismatches = 0;
		nTests = 0;
		lastRise = 0;
		repeat (12) @(negedge sys_clk);
		check("resetOutputs", {gateOn, chargeLowEn, chargeHighEn, softStartActive, burstActive, autoRestart}, 6'b010000);
		rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		check("lowChargeOnly", {gateOn, chargeLowEn, chargeHighEn}, 3'b010);
		shortPin = 1'b1;
		waitBit(chargeHighEn, 1'b1, 10);
		check("highCharge", {chargeLowEn, chargeHighEn, softStartActive}, 3'b010);
		onPin = 1'b1;
		waitBit(softStartActive, 1'b1, 10);
		check("softStartEntry", {chargeHighEn, softStartActive}, 2'b01);
		// Soft start: every peak sits at one of the four step limits, never falling back.
		seen = 4'h0;
		lastStep = 0;
		prevSs = 1'b0;
		do begin
			pulse(peak, onT, per, ss);
			if (ss === 1'b1) begin
				step = (peak - 301) / 125;
				check("softPeak", peak > 300 + 125 * step && peak <= 320 + 125 * step && step >= lastStep && step <= 3, 1);
				if (prevSs === 1'b1) begin
					check("softPeriodFixed", per, 307);
				end
				seen[step] = 1'b1;
				lastStep = step;
			end
			prevSs = ss;
		end while (ss === 1'b1 && nTests < 200);
		check("normalPeak", peak > 800 && peak <= 820, 1);
		check("softSteps", seen, 4'hF);
		check("softLength", ssLen >= 2795 && ssLen <= 2805, 1);
		// Table of ordinary cases; the first pulse after a change is let pass.
		loP = 9999;
		hiP = 0;
		foreach (rows[r]) begin
			fbCode = rows[r].fb;
			senseRamp = rows[r].ramp;
			pulse(peak, onT, per, ss);
			repeat (4) begin
				pulse(peak, onT, per, ss);
				check("rowPeak", peak > rows[r].lo && peak <= rows[r].lo + 2 * rows[r].ramp, 1);
				check("rowPeriod", per >= rows[r].per - 13 && per <= rows[r].per + 13, 1);
				if (rows[r].per == 12'h133) begin
					loP = (per < loP) ? per : loP;
					hiP = (per > hiP) ? per : hiP;
				end
			end
		end
		check("jitterSpread", hiP > loP, 1);
		// A sense level above every limit from the start is held off only by blanking.
		senseOffset = 12'h7D0;
		repeat (2) begin
			pulse(peak, onT, per, ss);
			check("blankingOnTime", onT >= 6 && onT <= 7, 1);
		end
		// A slow ramp never trips a comparison, so the duty ceiling ends the pulse.
		senseOffset = 12'h096;
		senseRamp = 12'h001;
		repeat (2) begin
			pulse(peak, onT, per, ss);
			check("dutyCeiling", onT >= 219 && onT <= 241, 1);
		end
		// Light load: burst entry, pause, reduced limit, exit.
		senseOffset = 12'h000;
		senseRamp = 12'h006;
		fbCode = 12'h03E8;
		waitBit(burstActive, 1'b1, 2000);
		check("burstEntry", burstActive, 1'b1);
		repeat (50) @(negedge sys_clk);
		quiet(700);
		fbCode = 12'h06A4;
		repeat (2) begin
			pulse(peak, onT, per, ss);
			check("burstPeak", peak > 270 && peak <= 282, 1);
		end
		fbCode = 12'h0BB8;
		waitBit(burstActive, 1'b0, 1000);
		check("burstExit", burstActive, 1'b0);
		// Sense stuck below the floor on three pulses forces auto restart.
		fbCode = 12'h0FA0;
		senseRamp = 12'h001;
		waitBit(autoRestart, 1'b1, 3000);
		check("floorRestart", {autoRestart, gateOn}, 2'b10);
		quiet(700);
		onPin = 1'b0;
		waitBit(chargeLowEn, 1'b1, 10);
		check("restartPrecharge", {autoRestart, chargeLowEn}, 2'b01);
		senseRamp = 12'h00A;
		onPin = 1'b1;
		waitBit(softStartActive, 1'b1, 20);
		check("softStartAgain", softStartActive, 1'b1);
		complete_run();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		complete_run();
	end
endmodule
`default_nettype wire
